// ===== rtl/asp_spi_slave.sv
// Serial slave port of a magnetic angle sensor: angle readout and config access
// How it works
// RQ1 - Accepts clock modes 0 and 3 without any configuration.
// RQ2 - Works at any serial clock rate up to 25 MHz; the port's 10 MHz synchronisers cannot sample a clock that fast.
// RQ3 - Master sends every command as exactly sixteen bits on MOSI.
// RQ4 - Master gives a seventeenth clock to fetch the check bit.
// RQ5 - Seventeenth bit makes the count of ones even.
// RQ6 - Capture on rising clock, launch on falling, MSB first, select idles high.
// RQ7 - Master keeps select high at least 150 ns between angle reads.
// RQ8 - Master keeps select high 750 ns around register frames.
// RQ9 - Master waits 20 ms between write request and its second frame.
// RQ10 - Early second frame after a write returns the old register value.
// RQ11 - Angle buffer reloads every microsecond while not frozen.
// RQ12 - Select falling freezes buffer and starts frame; rising releases it.
// RQ13 - Angle read sends sixteen bits MSB first; MOSI stays zero.
// RQ14 - Twelve bit angle: bits 15:4 then four zeros.
// RQ15 - Master may stop an angle read early by raising select.
// RQ16 - Fast repeated reads return the same angle until refreshed.
// RQ17 - Read request is 010, five address bits, eight zeros.
// RQ18 - Frame after a read request returns the byte in the upper half.
// RQ19 - Write request is 100, five address bits, eight data bits.
// RQ20 - Frame after a write request echoes the stored value.
// RQ21 - Written values persist and reload at power-on; the store here reloads factory values at reset instead.
// RQ22 - Register 27 shows field high flag bit 7, low flag bit 6.
// RQ23 - Clock level at select fall picks mode 0 or mode 3.
// RQ24 - While deselected MISO floats and clock and MOSI are ignored.
`timescale 1ns/1ps
module asp_spi_slave
  import asp_pkg::*;
#(
  parameter int NVM_CYCLES = NVM_WRITE_CYC  // Non-volatile commit time in clocks
)(
  input  wire logic        clk,              // 10 MHz system clock
  input  wire logic        reset,            // Asynchronous, active high
  input  wire logic        clk_en,           // Freezes all state while low
  input  wire logic        cs_n_pin,         // Chip select pin, active low
  input  wire logic        sclk_pin,         // Serial clock pin
  input  wire logic        mosi_pin,         // Serial data in pin
  output logic             miso_out,         // Serial data out
  output logic             miso_oe,          // MISO output enable, high drives
  input  wire logic [15:0] angle_in,         // Filtered angle from front end
  input  wire logic        field_high_flag,  // Field above high threshold
  input  wire logic        field_low_flag    // Field below low threshold
);
  // Two-flop synchronisers plus one edge stage, one lane per pin
  // Each serial clock level must last three system clocks, so the link rate is bound to the system clock
  logic [2:0] pin_in;
  logic [2:0] sync1_reg, sync2_reg, sync3_reg;
  assign pin_in = {mosi_pin, sclk_pin, cs_n_pin};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync1_reg[g] <= 1'b1;
          sync2_reg[g] <= 1'b1;
          sync3_reg[g] <= 1'b1;
        end else if (clk_en) begin
          sync1_reg[g] <= pin_in[g];  // RQ2
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
        end
      end
    end
  endgenerate

  logic cs_s, sclk_s, mosi_s, cs_fall, cs_rise, sclk_rise, sclk_fall;
  assign cs_s      = sync2_reg[0];
  assign sclk_s    = sync2_reg[1];
  assign mosi_s    = sync2_reg[2];
  assign cs_fall   = sync3_reg[0] & ~cs_s;
  assign cs_rise   = ~sync3_reg[0] & cs_s;
  assign sclk_rise = ~sync3_reg[1] & sclk_s & ~cs_s;   // RQ24
  assign sclk_fall = sync3_reg[1] & ~sclk_s & ~cs_s;   // RQ24

  typedef enum logic [1:0] {ASP_ANGLE, ASP_READ_RESP, ASP_WRITE_RESP} asp_resp_t;

  logic [3:0]  tick_reg, tick_next;
  logic [15:0] angle_reg, angle_next;
  logic [16:0] tx_reg, tx_next;
  logic [15:0] rx_reg, rx_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic        mode3_reg, mode3_next;
  logic        oe_reg, oe_next;
  asp_resp_t   resp_reg, resp_next;
  logic [4:0]  addr_reg, addr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic [4:0]  nvm_addr_reg, nvm_addr_next;
  logic [17:0] nvm_cnt_reg, nvm_cnt_next;
  logic        nvm_busy_reg, nvm_busy_next;
  logic        mem_we;
  logic [7:0]  mem_rdata, reg_byte;
  logic [15:0] word;
  logic [15:0] rx_full;
  logic        tick;

  asp_regmem u_mem (
    .clk   (clk),
    .reset (reset),
    .clk_en(clk_en),
    .we    (mem_we),
    .waddr (nvm_addr_reg),
    .wdata (wdata_reg),
    .raddr (addr_reg),
    .rdata (mem_rdata)
  );

  assign tick = (tick_reg == 4'(REFRESH_CYC - 1));
  assign rx_full = {rx_reg[14:0], mosi_s};

  always_comb begin
    reg_byte = mem_rdata;
    if (addr_reg == REG_FIELD_FLAGS) begin
      reg_byte = 8'h00;
      reg_byte[FIELD_HIGH_BIT] = field_high_flag;  // RQ22
      reg_byte[FIELD_LOW_BIT]  = field_low_flag;   // RQ22
    end
    // Busy commit has not reached the store yet, so the old byte is read
    word = (resp_reg == ASP_ANGLE) ? angle_reg : {reg_byte, 8'h00};  // RQ18 RQ10 RQ20
  end

  // Angle buffer refresh and freeze
  always_comb begin
    tick_next  = tick ? 4'h0 : tick_reg + 4'h1;
    angle_next = angle_reg;
    if (tick && cs_s) begin
      angle_next = angle_in & ANGLE_MASK;  // RQ11 RQ14 RQ16
    end
  end

  // Frame shifter
  always_comb begin
    tx_next    = tx_reg;
    rx_next    = rx_reg;
    cnt_next   = cnt_reg;
    mode3_next = mode3_reg;
    oe_next    = ~cs_s;  // RQ24
    resp_next  = resp_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    if (cs_fall) begin
      mode3_next = sclk_s;                 // RQ23 RQ1
      tx_next    = {word, ^word};          // RQ5 RQ12 RQ13
      cnt_next   = 5'h00;
      rx_next    = 16'h0000;
      resp_next  = ASP_ANGLE;
    end else if (!cs_s) begin
      if (sclk_rise && cnt_reg != PARITY_POS) begin
        rx_next  = rx_full;                // RQ6
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg == FRAME_LEN - 5'h01) begin
          if (rx_full[CMD_MSB -: 3] == CMD_READ) begin
            resp_next = ASP_READ_RESP;     // RQ17
            addr_next = rx_full[ADDR_MSB:ADDR_LSB];
          end else if (rx_full[CMD_MSB -: 3] == CMD_WRITE) begin
            resp_next  = ASP_WRITE_RESP;   // RQ19
            addr_next  = rx_full[ADDR_MSB:ADDR_LSB];
            wdata_next = rx_full[7:0];
          end
        end
      end
      // Mode 3 starts with a falling edge before any data; it must not shift
      if (sclk_fall && (!mode3_reg || cnt_reg != 5'h00)) begin
        tx_next = {tx_reg[15:0], 1'b0};    // RQ6 RQ15
      end
    end
  end

  // Commit timer for non-volatile writes
  always_comb begin
    nvm_cnt_next  = nvm_cnt_reg;
    nvm_busy_next = nvm_busy_reg;
    nvm_addr_next = nvm_addr_reg;
    mem_we        = 1'b0;
    if (!cs_s && sclk_rise && cnt_reg == FRAME_LEN - 5'h01 && rx_full[CMD_MSB -: 3] == CMD_WRITE) begin
      // Own copy of the address, so a read request during the commit cannot redirect it
      nvm_addr_next = rx_full[ADDR_MSB:ADDR_LSB];  // RQ21
      nvm_busy_next = 1'b1;
      nvm_cnt_next  = 18'(NVM_CYCLES - 1);
    end else if (nvm_busy_reg) begin
      if (nvm_cnt_reg == 18'h00000) begin
        mem_we        = 1'b1;              // RQ21
        nvm_busy_next = 1'b0;
      end else begin
        nvm_cnt_next = nvm_cnt_reg - 18'h00001;  // RQ10
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_reg     <= 4'h0;
      angle_reg    <= ANGLE_RESET;
      tx_reg       <= 17'h00000;
      rx_reg       <= 16'h0000;
      cnt_reg      <= 5'h00;
      mode3_reg    <= 1'b0;
      oe_reg       <= 1'b0;
      resp_reg     <= ASP_ANGLE;
      addr_reg     <= 5'h00;
      wdata_reg    <= 8'h00;
      nvm_cnt_reg  <= 18'h00000;
      nvm_busy_reg <= 1'b0;
      nvm_addr_reg <= 5'h00;
    end else if (clk_en) begin
      tick_reg     <= tick_next;
      angle_reg    <= angle_next;
      tx_reg       <= tx_next;
      rx_reg       <= rx_next;
      cnt_reg      <= cnt_next;
      mode3_reg    <= mode3_next;
      oe_reg       <= oe_next;
      resp_reg     <= resp_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      nvm_cnt_reg  <= nvm_cnt_next;
      nvm_busy_reg <= nvm_busy_next;
      nvm_addr_reg <= nvm_addr_next;
    end
  end

  assign miso_out = tx_reg[16];
  assign miso_oe  = oe_reg;

  // Checks
  a_deselect_hiz: assert property (@(posedge clk) disable iff (reset) // RQ24
    clk_en && cs_s |=> !miso_oe) else $error("MISO driven while deselected");
  a_select_drive: assert property (@(posedge clk) disable iff (reset) // RQ12
    clk_en && cs_fall |=> miso_oe && resp_reg == ASP_ANGLE) else $error("Frame start not driven");
  a_buffer_frozen: assert property (@(posedge clk) disable iff (reset) // RQ12
    !cs_s && $past(!cs_s) |-> $stable(angle_reg)) else $error("Angle changed while frozen");
  a_buffer_refresh: assert property (@(posedge clk) disable iff (reset) // RQ11
    clk_en && tick && cs_s |=> angle_reg == ($past(angle_in) & ANGLE_MASK)) else $error("Angle not refreshed");
  a_low_zero: assert property (@(posedge clk) disable iff (reset) // RQ14
    angle_reg[3:0] == 4'h0) else $error("Low angle bits not zero");
  a_even_parity: assert property (@(posedge clk) disable iff (reset) // RQ5
    clk_en && cs_fall |=> ^tx_reg == 1'b0) else $error("Odd parity loaded");
  a_msb_shift: assert property (@(posedge clk) disable iff (reset) // RQ6
    clk_en && sclk_fall && !cs_fall && cnt_reg != 5'h00 |=> miso_out == $past(tx_reg[15])) else $error("Bad shift");
  a_mode_pick: assert property (@(posedge clk) disable iff (reset) // RQ23
    clk_en && cs_fall |=> mode3_reg == $past(sclk_s)) else $error("Mode not latched");
  a_reg_low_zero: assert property (@(posedge clk) disable iff (reset) // RQ18
    clk_en && cs_fall && resp_reg != ASP_ANGLE |=> tx_reg[8:1] == 8'h00) else $error("Low byte not zero");
  a_nvm_hold: assert property (@(posedge clk) disable iff (reset) // RQ10
    clk_en && !nvm_busy_reg ##1 nvm_busy_reg |-> !mem_we [*2]) else $error("Commit too early");
  c_angle_full: cover property (@(posedge clk) disable iff (reset)
    resp_reg == ASP_ANGLE && cnt_reg == FRAME_LEN ##[1:300] cs_rise);
  c_read_req: cover property (@(posedge clk) disable iff (reset) resp_reg == ASP_READ_RESP ##[1:1000] cs_fall);
  c_commit: cover property (@(posedge clk) disable iff (reset) mem_we);
  c_mode3: cover property (@(posedge clk) disable iff (reset) cs_fall && sclk_s);
endmodule : asp_spi_slave

// ===== rtl/asp_pkg.sv
// Constants shared by the angle sensor serial port and its register store
package asp_pkg;
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          REFRESH_NS      = 1000;
  localparam int          REFRESH_CYC     = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NVM_WRITE_MS    = 20;
  localparam int          NVM_WRITE_CYC   = (NVM_WRITE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ANGLE_GAP_TIME_NS    = 150;
  localparam int          REGISTER_GAP_TIME_NS = 750;
  localparam int          FRAME_BITS      = 16;
  localparam logic [4:0]  FRAME_LEN       = 5'h10;
  localparam logic [4:0]  PARITY_POS      = 5'h11;
  localparam logic [2:0]  CMD_READ        = 3'h2;
  localparam logic [2:0]  CMD_WRITE       = 3'h4;
  localparam int          CMD_MSB         = 15;
  localparam int          ADDR_MSB        = 12;
  localparam int          ADDR_LSB        = 8;
  localparam logic [4:0]  REG_FIELD_FLAGS = 5'h1B;
  localparam int          FIELD_HIGH_BIT  = 7;
  localparam int          FIELD_LOW_BIT   = 6;
  localparam logic [15:0] ANGLE_MASK      = 16'hFFF0;
  localparam logic [15:0] ANGLE_RESET     = 16'h0000;
  localparam logic [7:0]  REG_DEFAULT     = 8'h00;
  localparam logic [4:0]  REG_ABZ_LO      = 5'h04;
  localparam logic [7:0]  DEF_ABZ_LO      = 8'hC0;
  localparam logic [4:0]  REG_ABZ_HI      = 5'h05;
  localparam logic [7:0]  DEF_ABZ_HI      = 8'h3F;
  localparam logic [4:0]  REG_THRESH      = 5'h06;
  localparam logic [7:0]  DEF_THRESH      = 8'h1C;
endpackage : asp_pkg

// ===== rtl/asp_regmem.sv
// Non-volatile configuration store: 32 bytes, factory values at power-on
`timescale 1ns/1ps
module asp_regmem
  import asp_pkg::*;
(
  input  wire logic       clk,      // System clock
  input  wire logic       reset,    // Power-on reset, reloads factory values
  input  wire logic       clk_en,   // Freezes state while low
  input  wire logic       we,       // Commit a byte
  input  wire logic [4:0] waddr,    // Commit address
  input  wire logic [7:0] wdata,    // Commit data
  input  wire logic [4:0] raddr,    // Read address
  output logic      [7:0] rdata     // Registered read data
);
  logic [7:0] mem_reg [32];
  logic [7:0] rdata_next;

  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_byte
      localparam logic [7:0] INIT = (i == int'(REG_ABZ_LO)) ? DEF_ABZ_LO :
                                    (i == int'(REG_ABZ_HI)) ? DEF_ABZ_HI :
                                    (i == int'(REG_THRESH)) ? DEF_THRESH : REG_DEFAULT;
      logic [7:0] byte_next;
      always_comb begin
        byte_next = mem_reg[i];
        if (we && waddr == 5'(i)) begin
          byte_next = wdata;
        end
      end
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          mem_reg[i] <= INIT; // RQ21
        end else if (clk_en) begin
          mem_reg[i] <= byte_next;
        end
      end
    end
  endgenerate

  always_comb begin
    rdata_next = mem_reg[raddr];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= REG_DEFAULT;
    end else if (clk_en) begin
      rdata <= rdata_next;
    end
  end
endmodule : asp_regmem

// ===== dv/asp_spi_master.sv
// Behavioural serial master that drives the angle sensor port from outside
`timescale 1ns/1ps
module asp_spi_master (
  input  wire logic clk,   // System clock, paces the serial clock
  output logic      cs_n,  // Chip select, active low
  output logic      sclk,  // Serial clock
  output logic      mosi,  // Serial data to the sensor
  input  wire logic miso   // Serial data from the sensor, pulled low when released
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // Four system clocks per half period give the 800 ns serial clock
  task automatic half;
    repeat (4) @(posedge clk);
    #1;
  endtask : half

  // Sampling just before the next fall leaves the port its full launch latency
  task automatic xfer(input logic mode3, input logic [15:0] tx, input int nclk, output logic [16:0] rx);
    rx = '0;
    sclk = mode3;
    half();
    cs_n = 1'b0;
    half();
    half();
    for (int i = 0; i < nclk; i++) begin
      sclk = 1'b0;
      mosi = (i < 16) ? tx[15 - i] : 1'b0;
      half();
      sclk = 1'b1;
      half();
      rx = {rx[15:0], miso};
    end
    sclk = mode3;
    mosi = 1'b0;
    half();
    cs_n = 1'b1;
    half();
    half();
  endtask : xfer
endmodule : asp_spi_master

// ===== dv/tb_top.sv
// Self-checking bench for the angle sensor serial port
`timescale 1ns/1ps
module tb_top;
  import asp_pkg::*;
  localparam int NVM_SIM = 400;
  logic        clk;
  logic        reset;
  logic        cs_n;
  logic        sclk;
  logic        mosi;
  logic        miso_out;
  logic        miso_oe;
  logic        miso_wire;
  logic        fh;
  logic        fl;
  logic [15:0] angle;
  logic [16:0] rx;
  int          num_errors;
  int          n_tests;

  // Pull-down on the data-out line when the port releases it
  assign miso_wire = miso_oe ? miso_out : 1'b0;

  asp_spi_slave #(.NVM_CYCLES(NVM_SIM)) dut (
    .clk(clk), .reset(reset), .clk_en(1'b1), .cs_n_pin(cs_n), .sclk_pin(sclk), .mosi_pin(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe), .angle_in(angle), .field_high_flag(fh), .field_low_flag(fl)
  );
  asp_spi_master master (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso_wire));

  always #50 clk = ~clk;

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [16:0] framed(input logic [15:0] d);
    return {d, ^d};
  endfunction : framed

  task automatic read_reg(input logic m, input logic [4:0] a, output logic [16:0] r);
    master.xfer(m, {CMD_READ, a, 8'h00}, 16, r);
    master.xfer(m, 16'h0000, 17, r);
  endtask : read_reg

  task automatic t_reset;
    check({16'h0, miso_oe}, 17'h0);
    read_reg(1'b0, REG_THRESH, rx);
    check(rx, framed({8'h1C, 8'h00}));
    read_reg(1'b1, REG_ABZ_LO, rx);
    check(rx, framed({8'hC0, 8'h00}));
  endtask : t_reset

  task automatic t_angle;
    logic [15:0] v [2] = '{16'h5A5F, 16'hC3B7};
    for (int m = 0; m < 2; m++) begin
      angle = v[m];
      // Let the buffer take the new sample before select falls
      repeat (REFRESH_CYC + 2) @(posedge clk);
      #1;
      master.xfer(m[0], 16'h0000, 17, rx);
      check(rx, framed(v[m] & ANGLE_MASK));
    end
    check({16'h0, miso_oe}, 17'h0);
  endtask : t_angle

  task automatic t_freeze;
    angle = 16'h1234;
    repeat (12) @(posedge clk);
    #1;
    fork
      master.xfer(1'b0, 16'h0000, 17, rx);
      begin
        repeat (20) @(posedge clk);
        #1;
        angle = 16'hFFFF;
      end
    join
    check(rx, framed(16'h1230));
    master.xfer(1'b0, 16'h0000, 17, rx);
    check(rx, framed(16'hFFF0));
  endtask : t_freeze

  task automatic t_partial;
    angle = 16'hABCD;
    repeat (REFRESH_CYC + 2) @(posedge clk);
    #1;
    master.xfer(1'b1, 16'h0000, 12, rx);
    check(rx, {5'h0, 12'hABC});
    master.xfer(1'b0, 16'h0000, 17, rx);
    check(rx, framed(16'hABC0));
  endtask : t_partial

  task automatic t_flags;
    for (int k = 0; k < 4; k++) begin
      fh = k[1];
      fl = k[0];
      read_reg(k[0], REG_FIELD_FLAGS, rx);
      check(rx, framed({k[1], k[0], 6'h00, 8'h00}));
    end
  endtask : t_flags

  // Slow write: second frame after the commit has finished
  task automatic t_write;
    master.xfer(1'b0, {CMD_WRITE, 5'h09, 8'h81}, 16, rx);
    repeat (3 * NVM_SIM) @(posedge clk);
    #1;
    master.xfer(1'b0, 16'h0000, 17, rx);
    check(rx, framed({8'h81, 8'h00}));
    read_reg(1'b1, 5'h09, rx);
    check(rx, framed({8'h81, 8'h00}));
  endtask : t_write

  task automatic t_early;
    master.xfer(1'b1, {CMD_WRITE, REG_ABZ_HI, 8'h12}, 16, rx);
    master.xfer(1'b1, 16'h0000, 17, rx);
    check(rx, framed({8'h3F, 8'h00}));
    // A read request while the commit is still running must not redirect it
    read_reg(1'b0, REG_THRESH, rx);
    check(rx, framed({8'h1C, 8'h00}));
    repeat (3 * NVM_SIM) @(posedge clk);
    #1;
    read_reg(1'b0, REG_ABZ_HI, rx);
    check(rx, framed({8'h12, 8'h00}));
    read_reg(1'b1, REG_THRESH, rx);
    check(rx, framed({8'h1C, 8'h00}));
  endtask : t_early

  task automatic final_report;
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // Watchdog: the whole run stays far below this bound
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    angle = 16'h0000;
    fh = 1'b0;
    fl = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_angle();
    t_freeze();
    t_partial();
    t_flags();
    t_write();
    t_early();
    final_report();
  end
endmodule : tb_top
